// *** verilog/fre_regs.vh ***
// constants for the flash row erase controller
`ifndef FRE_REGS_VH
`define FRE_REGS_VH

`define FRE_UNLOCK_KEY1 8'h55
`define FRE_UNLOCK_KEY2 8'hAA
`define FRE_ROW_WORDS 6'h20
`define FRE_ROW_IDX_W 5
`define FRE_WORD_W 14
`define FRE_BLANK_WORD 14'h3FFF
`define FRE_PFM_TOP 14'h3FFF
`define FRE_UID_TOP 14'h0003
`define FRE_ID_LO 14'h0005
`define FRE_ID_HI 14'h000A
`define FRE_EE_LO 14'h3000
`define FRE_EE_HI 14'h30FF
`define FRE_ERASE_CYCLE_NS 20
`define FRE_CLK_NS 20
`define FRE_ERASE_WORD_CYC ((`FRE_ERASE_CYCLE_NS + `FRE_CLK_NS - 1) / `FRE_CLK_NS)

`endif

// *** verilog/fre_flash_row_erase_control.v ***
// flash row erase sequencer with unlock, protection and address decode
//
// Overview of operation
// - erase whole rows only, one per operation
// - program writes never erase implicitly
// - region select chooses flash or user IDs
// - address loaded, erase and write enable set
// - 55h then AAh then start launches erase
// - protected row clears start, no erase
// - CPU stalled for entire erase duration
// - done flag set; irq only when enabled
// - erase leaves latches and write enable alone
// - any row address selects row; 8+6 bits
// - decode address map by region select
// - code protection blocks address map reads, writes and erase
`timescale 1ns/1ps
`include "fre_regs.vh"

module fre_flash_row_erase_control (
  // clock and reset
  input wire clk,
  input wire arst_n,
  input wire clkEn,
  // software register writes
  input wire addrLowWe,
  input wire addrHighWe,
  input wire [7:0] wrData,
  input wire unlockWe,
  input wire ctrlWe,
  input wire regionSelectIn,
  input wire eraseSelectIn,
  input wire writeEnableIn,
  input wire startIn,
  input wire opDoneClr,
  input wire opDoneIrqEnable,
  // protection
  input wire codeProtect,
  input wire rowWriteProtect,
  // flash array side
  input wire flashAck,
  output reg flashEraseReq,
  output reg flashRegion,
  output reg [8:0] flashRow,
  output reg [4:0] flashWordIdx,
  output reg [13:0] flashWordData,
  // status and cpu
  output reg regionSelect_r,
  output reg eraseSelect_r,
  output reg writeEnable_r,
  output reg start_r,
  output reg opDoneFlag_r,
  output wire opDoneIrq,
  output wire cpuStall,
  output reg [7:0] addrLow_r,
  output reg [5:0] addrHigh_r,
  output wire addrReadable,
  output wire addrWritable,
  output wire addrIsEeprom
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_KEY1 = 2'h1;
  localparam ST_KEY2 = 2'h2;
  localparam ST_ERASE = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [5:0] wordCnt_r;
  reg [7:0] waitCnt_r;

  wire [13:0] fullAddr = {addrHigh_r, addrLow_r};

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  reg inPfm;
  reg inUid;
  reg inId;
  reg inEe;

  // region map decode
  // region 1 holds three windows with gaps between them
  always @* begin
    inPfm = 1'b0;
    inUid = 1'b0;
    inId = 1'b0;
    inEe = 1'b0;
    if (!regionSelect_r) begin
      inPfm = (fullAddr <= `FRE_PFM_TOP);
    end else if (fullAddr <= `FRE_UID_TOP) begin
      inUid = 1'b1;
    end else if ((fullAddr >= `FRE_ID_LO) && (fullAddr <= `FRE_ID_HI)) begin
      inId = 1'b1;
    end else if ((fullAddr >= `FRE_EE_LO) && (fullAddr <= `FRE_EE_HI)) begin
      inEe = 1'b1;
    end
  end
  assign addrReadable = ~codeProtect && (inPfm || inUid || inId || inEe);
  assign addrWritable = ~codeProtect && (inPfm || inUid || inEe);
  assign addrIsEeprom = inEe;

  // only flash or user-ID rows may be erased
  wire eraseTargetOk = inPfm || inUid;

  wire prepared = eraseSelect_r && writeEnable_r;
  wire refuse = codeProtect || (rowWriteProtect && ~regionSelect_r) || ~eraseTargetOk;

  // ------------------------------------------------------------
  // unlock sequence
  // ------------------------------------------------------------
  // ordered unlock keys
  // any other write between steps aborts
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (unlockWe && wrData == `FRE_UNLOCK_KEY1) begin
          state_nxt = ST_KEY1;
        end
      end
      ST_KEY1: begin
        if (unlockWe && wrData == `FRE_UNLOCK_KEY2) begin
          state_nxt = ST_KEY2;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_KEY2: begin
        if (ctrlWe && startIn && prepared && ~refuse) begin
          state_nxt = ST_ERASE;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (wordCnt_r == `FRE_ROW_WORDS) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign cpuStall = (state_r == ST_ERASE);
  assign opDoneIrq = opDoneFlag_r && opDoneIrqEnable;

  wire eraseDone = (state_r == ST_ERASE) && (wordCnt_r == `FRE_ROW_WORDS);
  wire wordStep = (state_r == ST_ERASE) && flashAck &&
                  (waitCnt_r >= `FRE_ERASE_WORD_CYC - 1);

  // ------------------------------------------------------------
  // launch and step strobes
  // ------------------------------------------------------------
  // erase launched only by start straight after both keys
  // a refused start drops back to idle and never reaches this
  wire launch = (state_r == ST_KEY2) && (state_nxt == ST_ERASE);
  // address and control writes locked out while the row is erased
  wire regWriteOpen = (state_r != ST_ERASE);
  // last word of the row goes to the array on this step
  wire lastWord = wordStep && (wordCnt_r == `FRE_ROW_WORDS - 6'h01);

  // ------------------------------------------------------------
  // unlock state register
  // ------------------------------------------------------------
  // clkEn low freezes every register of the block
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // address register pair
  // ------------------------------------------------------------
  // address pair load
  // frozen while erasing so the row cannot shift under the array
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addrLow_r <= 8'h00;
      addrHigh_r <= 6'h00;
    end else if (clkEn) begin
      if (addrLowWe && regWriteOpen) begin
        addrLow_r <= wrData;
      end
      if (addrHighWe && regWriteOpen) begin
        addrHigh_r <= wrData[5:0];
      end
    end
  end

  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  // write enable changed only by software, never by erase
  // one control write loads all three bits together
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regionSelect_r <= 1'b0;
      eraseSelect_r <= 1'b0;
      writeEnable_r <= 1'b0;
    end else if (clkEn) begin
      if (ctrlWe && regWriteOpen) begin
        regionSelect_r <= regionSelectIn;
        eraseSelect_r <= eraseSelectIn;
        writeEnable_r <= writeEnableIn;
      end
    end
  end

  // ------------------------------------------------------------
  // start bit
  // ------------------------------------------------------------
  // start cleared when refused
  // a refused start never rises, so software sees it low at once
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_r <= 1'b0;
    end else if (clkEn) begin
      if (launch) begin
        start_r <= 1'b1;
      end else if (eraseDone || regWriteOpen) begin
        start_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // completion flag
  // ------------------------------------------------------------
  // completion flag, set beats clear
  // a clear in the finishing cycle must not lose the event
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opDoneFlag_r <= 1'b0;
    end else if (clkEn) begin
      if (eraseDone) begin
        opDoneFlag_r <= 1'b1;
      end else if (opDoneClr) begin
        opDoneFlag_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // word and wait counters
  // ------------------------------------------------------------
  // whole row walked word by word from index zero
  // one word per accepted array handshake
  // wait counter saturates so a stuck array cannot wrap it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wordCnt_r <= 6'h00;
      waitCnt_r <= 8'h00;
    end else if (clkEn) begin
      if (launch) begin
        wordCnt_r <= 6'h00;
        waitCnt_r <= 8'h00;
      end else if (wordStep && !eraseDone) begin
        wordCnt_r <= wordCnt_r + 6'h01;
        waitCnt_r <= 8'h00;
      end else if (cpuStall && !eraseDone && waitCnt_r != 8'hFF) begin
        waitCnt_r <= waitCnt_r + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // flash array request
  // ------------------------------------------------------------
  // whole row latched at launch
  // row and region held for the whole erase, not re-read per word
  // index wraps to zero after the last word while request is low
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flashEraseReq <= 1'b0;
      flashRegion <= 1'b0;
      flashRow <= 9'h000;
      flashWordIdx <= 5'h00;
      flashWordData <= 14'h0000;
    end else if (clkEn) begin
      if (launch) begin
        flashRegion <= regionSelect_r;
        flashRow <= fullAddr[13:5];
        flashWordIdx <= 5'h00;
        flashEraseReq <= 1'b1;
        // blank value written to every word
        flashWordData <= `FRE_BLANK_WORD;
      end else if (eraseDone) begin
        flashEraseReq <= 1'b0;
      end else if (wordStep) begin
        flashWordIdx <= wordCnt_r[4:0] + 5'h01;
        if (lastWord) begin
          flashEraseReq <= 1'b0;
        end
      end
    end
  end

endmodule

// *** verif/fre_erase_props.sv ***
// assertions on the row erase controller ports
`timescale 1ns/1ps
module fre_erase_props (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // requests
  input wire unlockWe,
  input wire ctrlWe,
  input wire startIn,
  input wire codeProtect,
  input wire rowWriteProtect,
  input wire opDoneIrqEnable,
  input wire [7:0] wrData,
  // status
  input wire regionSelect_r,
  input wire flashEraseReq,
  input wire writeEnable_r,
  input wire start_r,
  input wire opDoneFlag_r,
  input wire opDoneIrq,
  input wire cpuStall,
  input wire [8:0] flashRow,
  input wire [13:0] flashWordData,
  input wire [7:0] addrLow_r,
  input wire [5:0] addrHigh_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence seq_keys;
    unlockWe && wrData == 8'h55 ##1 unlockWe && wrData == 8'hAA;
  endsequence
  a_start_needs_key: assert property ($rose(start_r) |-> $past(ctrlWe) &&
    $past(startIn) && $past(unlockWe, 2) && $past(wrData, 2) == 8'hAA &&
    $past(unlockWe, 3) && $past(wrData, 3) == 8'h55)
    else $error("start without keys");
  a_protected_row_refused: assert property (seq_keys ##1 (ctrlWe && startIn &&
    !regionSelect_r && rowWriteProtect) |=> !start_r) else $error("protected row erased");
  a_code_protect_blocks: assert property (seq_keys ##1 (ctrlWe && startIn &&
    codeProtect) |=> !start_r) else $error("erase under code protect");
  a_stall_whole_erase: assert property (flashEraseReq |-> cpuStall && start_r)
    else $error("cpu not stalled");
  a_irq_gated: assert property (opDoneIrq == (opDoneFlag_r && opDoneIrqEnable))
    else $error("irq gating wrong");
  a_done_keeps_write_enable_bit: assert property ($fell(start_r) |-> opDoneFlag_r && writeEnable_r)
    else $error("end of erase wrong");
  a_blank_words: assert property (flashEraseReq |-> flashWordData == 14'h3FFF)
    else $error("erase data not blank");
  a_row_from_addr: assert property (flashEraseReq |->
    flashRow == {addrHigh_r, addrLow_r[7:5]}) else $error("wrong row");
endmodule

bind fre_flash_row_erase_control fre_erase_props props_u (
  .clk(clk),
  .arst_n(arst_n),
  .unlockWe(unlockWe),
  .ctrlWe(ctrlWe),
  .startIn(startIn),
  .codeProtect(codeProtect),
  .rowWriteProtect(rowWriteProtect),
  .opDoneIrqEnable(opDoneIrqEnable),
  .wrData(wrData),
  .regionSelect_r(regionSelect_r),
  .flashEraseReq(flashEraseReq),
  .writeEnable_r(writeEnable_r),
  .start_r(start_r),
  .opDoneFlag_r(opDoneFlag_r),
  .opDoneIrq(opDoneIrq),
  .cpuStall(cpuStall),
  .flashRow(flashRow),
  .flashWordData(flashWordData),
  .addrLow_r(addrLow_r),
  .addrHigh_r(addrHigh_r)
);

// *** verif/fre_flash_model.sv ***
// flash array stand-in accepting word erases
`timescale 1ns/1ps
module fre_flash_model (
  input wire clk,
  input wire flashEraseReq,
  input wire slow,
  output wire flashAck
);
  reg tog_r = 1'b0;
  always @(posedge clk) begin
    tog_r <= !tog_r;
  end
  // slow mode takes a word only every other cycle
  assign flashAck = flashEraseReq && (!slow || tog_r);
endmodule

// *** verif/fre_flash_row_erase_control_tb_top.sv ***
// self-checking bench for the row erase controller
`timescale 1ns/1ps
module fre_flash_row_erase_control_tb_top;
  reg clk = 0, arst_n = 0, addrLowWe = 0, addrHighWe = 0, unlockWe = 0, ctrlWe = 0;
  reg regionSelectIn = 0, eraseSelectIn = 0, writeEnableIn = 0, startIn = 0, opDoneClr = 0;
  reg opDoneIrqEnable = 0, codeProtect = 0, rowWriteProtect = 0, slow = 0, rg, good;
  reg [7:0] wrData = 0;
  reg clkEn = 1;
  wire flashAck, flashEraseReq, flashRegion, regionSelect_r, eraseSelect_r, writeEnable_r;
  wire start_r, opDoneFlag_r, opDoneIrq, cpuStall, addrReadable, addrWritable, addrIsEeprom;
  wire [8:0] flashRow;
  wire [4:0] flashWordIdx;
  wire [13:0] flashWordData, a;
  wire [7:0] addrLow_r;
  wire [5:0] addrHigh_r;
  int n_fail = 0, checks = 0, w, j;
  logic [31:0] rnd = 32'h08BB;
  logic [9:0] seenRow;
  always #10 clk = !clk;
  fre_flash_row_erase_control dut_u (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn),
    .addrLowWe(addrLowWe), .addrHighWe(addrHighWe),
    .wrData(wrData), .unlockWe(unlockWe), .ctrlWe(ctrlWe), .regionSelectIn(regionSelectIn),
    .eraseSelectIn(eraseSelectIn), .writeEnableIn(writeEnableIn), .startIn(startIn),
    .opDoneClr(opDoneClr), .opDoneIrqEnable(opDoneIrqEnable), .codeProtect(codeProtect),
    .rowWriteProtect(rowWriteProtect), .flashAck(flashAck), .flashEraseReq(flashEraseReq),
    .flashRegion(flashRegion), .flashRow(flashRow), .flashWordIdx(flashWordIdx),
    .flashWordData(flashWordData), .regionSelect_r(regionSelect_r),
    .eraseSelect_r(eraseSelect_r), .writeEnable_r(writeEnable_r), .start_r(start_r),
    .opDoneFlag_r(opDoneFlag_r), .opDoneIrq(opDoneIrq), .cpuStall(cpuStall),
    .addrLow_r(addrLow_r), .addrHigh_r(addrHigh_r), .addrReadable(addrReadable),
    .addrWritable(addrWritable), .addrIsEeprom(addrIsEeprom));
  fre_flash_model model_u (.clk(clk), .flashEraseReq(flashEraseReq), .slow(slow),
    .flashAck(flashAck));
  assign a = j == 5 ? {12'h000, rnd[1:0]} : j == 10 ? 14'h0007 : j == 11 ? 14'h3005 : rnd[13:0];
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] target(input logic r, input logic [13:0] x);
    return {r, x[13:5]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // address, control, then keys back to back
  task automatic run(input logic [7:0] k);
    @(negedge clk) addrLowWe = 1;
    wrData = a[7:0];
    @(negedge clk) addrLowWe = 0;
    addrHighWe = 1;
    wrData = {2'h0, a[13:8]};
    @(negedge clk) addrHighWe = 0;
    ctrlWe = 1;
    {regionSelectIn, eraseSelectIn, writeEnableIn} = {rg, j != 7, 1'b1};
    @(negedge clk) ctrlWe = 0;
    unlockWe = 1;
    wrData = 8'h55;
    @(negedge clk) wrData = k;
    @(negedge clk) unlockWe = 0;
    ctrlWe = 1;
    startIn = 1;
    @(negedge clk) ctrlWe = 0;
    startIn = 0;
  endtask
  task automatic waitDone;
    w = 0;
    for (int i = 0; i < 200 && start_r; i++) begin
      if (w == 0) seenRow = {flashRegion, flashRow};
      chk(cpuStall, 1);
      if (flashEraseReq && flashAck) begin
        chk(flashWordIdx, w);
        chk(flashWordData, 14'h3FFF);
        w++;
      end
      @(negedge clk);
    end
    if (start_r) begin
      n_fail++;
      tally_and_finish;
    end else begin
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1;
    chk({start_r, cpuStall, opDoneFlag_r, flashEraseReq}, 0);
    // clock enable low must freeze the low address byte
    @(negedge clk) clkEn = 0;
    addrLowWe = 1;
    wrData = 8'h5A;
    @(negedge clk) chk(addrLow_r, 8'h00);
    addrLowWe = 0;
    clkEn = 1;
    for (j = 0; j < 12; j++) begin
      rnd = lfsr(lfsr(rnd));
      {slow, opDoneIrqEnable} = rnd[21:20];
      rg = j == 5 || j > 9;
      good = j < 6;
      codeProtect = j == 8;
      rowWriteProtect = j == 5 || j == 9;
      run(j == 6 || j == 11 ? 8'hA5 : 8'hAA);
      waitDone;
      chk(w, good ? 32 : 0);
      chk(opDoneFlag_r, good);
      chk(opDoneIrq, good && opDoneIrqEnable);
      chk(writeEnable_r, 1);
      if (good) chk(seenRow, target(rg, a));
      if (j == 10) chk({addrReadable, addrWritable}, 2'b10);
      if (j == 11) chk({addrIsEeprom, addrWritable}, 2'b11);
      chk(cpuStall, 0);
      chk({addrHigh_r, addrLow_r}, a);
      chk({regionSelect_r, eraseSelect_r}, {rg, j != 7});
      if (j == 8) chk({addrReadable, addrWritable}, 2'b00);
      @(negedge clk) opDoneClr = 1;
      @(negedge clk) opDoneClr = 0;
    end
    tally_and_finish;
  end
endmodule
